// ### hw/bac_pkg.sv
// Constants, register map and types for the accumulated error-rate controller.
package bac_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_MODE = 8'h04;
    localparam logic [7:0] OFF_DUR = 8'h08;
    localparam logic [7:0] OFF_BITLIM_LO = 8'h0C;
    localparam logic [7:0] OFF_BITLIM_HI = 8'h10;
    localparam logic [7:0] OFF_ERRLIM = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h1C;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
    localparam logic [7:0] OFF_BITS_LO = 8'h24;
    localparam logic [7:0] OFF_BITS_HI = 8'h28;
    localparam logic [7:0] OFF_ERRS = 8'h2C;
    localparam logic [7:0] OFF_ERR1 = 8'h30;
    localparam logic [7:0] OFF_ERR0 = 8'h34;
    localparam logic [7:0] OFF_ELAPSED = 8'h38;
    localparam logic [7:0] OFF_RATIO = 8'h3C;

    // Command bits of the control register.
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_CLEAR = 2;

    // Interrupt status and mask bits.
    localparam int IRQ_DONE = 0;
    localparam int IRQ_REJECT = 1;
    localparam int IRQ_W = 2;

    // Stop criteria.
    localparam logic [1:0] MODE_MANUAL = 2'h0;
    localparam logic [1:0] MODE_DURATION = 2'h1;
    localparam logic [1:0] MODE_BITS = 2'h2;
    localparam logic [1:0] MODE_ERRORS = 2'h3;

    // Limits; time is held in tenths of a second.
    localparam logic [31:0] MAX_TENTHS = 32'h05F5_E0FF;
    localparam logic [63:0] BITLIM_MIN = 64'h0000_0000_05F5_E100;
    localparam logic [63:0] BITLIM_MAX = 64'h0163_4578_5D8A_0000;
    localparam logic [31:0] ERRLIM_MIN = 32'h0000_0001;
    localparam logic [31:0] ERRLIM_MAX = 32'h05F5_E0FF;

    // Timing: one elapsed-time step is a tenth of a second.
    localparam int TENTH_SECOND_NS = 100_000_000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_CYCLES = TENTH_SECOND_NS / CLK_PERIOD_NS;

    // Ratio divider produces a 32-bit binary fraction.
    localparam int RATIO_W = 32;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } bac_state_t;
endpackage

// ### hw/bac_top.sv
// Accumulated error-rate measurement controller with an AXI4-Lite register slave.
//
// Overview of operation
// - Start begins new measurement counting bits, errors.
// - Manual mode runs until 9999999.9 seconds ceiling.
// - Duration mode stops when elapsed reaches limit.
// - Duration in tenths, at most 9999999.9 s.
// - Bit mode stops at limit, 1E8..1E17.
// - Error mode stops at limit, 1..99999999.
// - Clear resets results only while stopped.
// - Running errored-bit count is readable.
// - Separate error counts for expected ones, zeros.
// - Readable elapsed time advances while running.
// - Accumulated error ratio is readable.
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module bac_top #(
    parameter int TICK_CYCLES = bac_pkg::TICK_CYCLES,
    parameter int CNT_W = 64
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [bac_pkg::ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [bac_pkg::ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic cmp_valid_in,
    input wire logic cmp_error_in,
    input wire logic cmp_expected_in,
    output logic running_out,
    output logic irq_out
);
    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    bac_pkg::bac_state_t state, next_state;
    logic aw_got, next_aw_got;
    logic w_got, next_w_got;
    logic [bac_pkg::ADDR_W-1:0] aw_addr, next_aw_addr, rd_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic awready, next_awready, wready, next_wready, bvalid, next_bvalid;
    logic arready, next_arready, rvalid, next_rvalid;
    logic [1:0] bresp, next_bresp, rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic [1:0] mode, next_mode;
    logic [31:0] dur_lim, next_dur_lim, err_lim, next_err_lim;
    logic [63:0] bit_lim, next_bit_lim;
    logic [bac_pkg::IRQ_W-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
    logic irq, next_irq;
    logic [CNT_W-1:0] bit_cnt, next_bit_cnt;
    logic [31:0] err_cnt, next_err_cnt, err1_cnt, next_err1_cnt, err0_cnt, next_err0_cnt;
    logic [31:0] elapsed, next_elapsed, tick, next_tick;
    logic [31:0] ratio, next_ratio, quot, next_quot;
    logic [CNT_W:0] rem, next_rem;
    logic [CNT_W-1:0] den, next_den;
    logic [5:0] div_step, next_div_step;
    logic wr_fire, start_cmd, stop_cmd, clear_cmd, rd_clr, limit_ok, stop_evt, reject_evt;
    logic [CNT_W:0] rem_shift;

    always_comb
    begin
        next_state = state;
        next_aw_got = aw_got;
        next_w_got = w_got;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        next_mode = mode;
        next_dur_lim = dur_lim;
        next_err_lim = err_lim;
        next_bit_lim = bit_lim;
        next_irq_mask = irq_mask;
        next_bit_cnt = bit_cnt;
        next_err_cnt = err_cnt;
        next_err1_cnt = err1_cnt;
        next_err0_cnt = err0_cnt;
        next_elapsed = elapsed;
        next_tick = tick;
        next_ratio = ratio;
        next_quot = quot;
        next_rem = rem;
        next_den = den;
        next_div_step = div_step;
        start_cmd = 1'b0;
        stop_cmd = 1'b0;
        clear_cmd = 1'b0;
        rd_clr = 1'b0;
        stop_evt = 1'b0;
        reject_evt = 1'b0;
        rem_shift = '0;
        rd_addr = s_axi_araddr_in;

        // Address and data are held separately so the master may present them in either order.
        if (s_axi_awvalid_in && awready)
        begin
            next_aw_got = 1'b1;
            next_aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && wready)
        begin
            next_w_got = 1'b1;
            next_w_data = s_axi_wdata_in;
            next_w_strb = s_axi_wstrb_in;
        end
        if (bvalid && s_axi_bready_in)
        begin
            next_bvalid = 1'b0;
        end
        wr_fire = aw_got && w_got && !bvalid;
        if (wr_fire)
        begin
            next_aw_got = 1'b0;
            next_w_got = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = bac_pkg::RESP_OKAY;
            if (aw_addr == bac_pkg::OFF_CTRL)
            begin
                start_cmd = w_strb[0] && w_data[bac_pkg::CTRL_START];
                stop_cmd = w_strb[0] && w_data[bac_pkg::CTRL_STOP];
                clear_cmd = w_strb[0] && w_data[bac_pkg::CTRL_CLEAR];
            end
            else if (aw_addr == bac_pkg::OFF_MODE)
            begin
                next_mode = w_strb[0] ? w_data[1:0] : mode;
            end
            else if (aw_addr == bac_pkg::OFF_DUR)
            begin
                next_dur_lim = merge_bytes(dur_lim, w_data, w_strb);
            end
            else if (aw_addr == bac_pkg::OFF_BITLIM_LO)
            begin
                next_bit_lim[31:0] = merge_bytes(bit_lim[31:0], w_data, w_strb);
            end
            else if (aw_addr == bac_pkg::OFF_BITLIM_HI)
            begin
                next_bit_lim[63:32] = merge_bytes(bit_lim[63:32], w_data, w_strb);
            end
            else if (aw_addr == bac_pkg::OFF_ERRLIM)
            begin
                next_err_lim = merge_bytes(err_lim, w_data, w_strb);
            end
            else if (aw_addr == bac_pkg::OFF_IRQ_MASK)
            begin
                next_irq_mask = w_strb[0] ? w_data[bac_pkg::IRQ_W-1:0] : irq_mask;
            end
            else if (aw_addr > bac_pkg::OFF_RATIO || aw_addr[1:0] != 2'h0)
            begin
                next_bresp = bac_pkg::RESP_SLVERR;
            end
        end

        if (rvalid && s_axi_rready_in)
        begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid_in && arready)
        begin
            next_rvalid = 1'b1;
            next_rresp = bac_pkg::RESP_OKAY;
            next_rdata = 32'h0;
            if (rd_addr == bac_pkg::OFF_MODE)
                next_rdata = {30'h0, mode};
            else if (rd_addr == bac_pkg::OFF_DUR)
                next_rdata = dur_lim;
            else if (rd_addr == bac_pkg::OFF_BITLIM_LO)
                next_rdata = bit_lim[31:0];
            else if (rd_addr == bac_pkg::OFF_BITLIM_HI)
                next_rdata = bit_lim[63:32];
            else if (rd_addr == bac_pkg::OFF_ERRLIM)
                next_rdata = err_lim;
            else if (rd_addr == bac_pkg::OFF_CTRL || rd_addr == bac_pkg::OFF_STATUS)
                next_rdata = {31'h0, state == bac_pkg::ST_RUN};
            else if (rd_addr == bac_pkg::OFF_IRQ_STAT)
            begin
                next_rdata = {30'h0, irq_stat};
                rd_clr = 1'b1;
            end
            else if (rd_addr == bac_pkg::OFF_IRQ_MASK)
                next_rdata = {30'h0, irq_mask};
            else if (rd_addr == bac_pkg::OFF_BITS_LO)
                next_rdata = bit_cnt[31:0];
            else if (rd_addr == bac_pkg::OFF_BITS_HI)
                next_rdata = bit_cnt[63:32];
            else if (rd_addr == bac_pkg::OFF_ERRS)
                next_rdata = err_cnt;
            else if (rd_addr == bac_pkg::OFF_ERR1)
                next_rdata = err1_cnt;
            else if (rd_addr == bac_pkg::OFF_ERR0)
                next_rdata = err0_cnt;
            else if (rd_addr == bac_pkg::OFF_ELAPSED)
                next_rdata = elapsed;
            else if (rd_addr == bac_pkg::OFF_RATIO)
                next_rdata = ratio;
            else
                next_rresp = bac_pkg::RESP_SLVERR;
        end
        next_awready = !next_aw_got && !next_bvalid;
        next_wready = !next_w_got && !next_bvalid;
        next_arready = !next_rvalid;

        // A start whose selected limit is out of range is refused and flagged.
        case (mode)
            bac_pkg::MODE_DURATION: limit_ok = dur_lim != 32'h0 && dur_lim <= bac_pkg::MAX_TENTHS;
            bac_pkg::MODE_BITS: limit_ok = bit_lim >= bac_pkg::BITLIM_MIN && bit_lim <= bac_pkg::BITLIM_MAX;
            bac_pkg::MODE_ERRORS: limit_ok = err_lim >= bac_pkg::ERRLIM_MIN && err_lim <= bac_pkg::ERRLIM_MAX;
            default: limit_ok = 1'b1;
        endcase

        case (state)
            bac_pkg::ST_IDLE:
            begin
                if (clear_cmd || (start_cmd && limit_ok))
                begin
                    next_bit_cnt = '0;
                    next_err_cnt = '0;
                    next_err1_cnt = '0;
                    next_err0_cnt = '0;
                    next_elapsed = '0;
                    next_tick = '0;
                    next_ratio = '0;
                end
                if (start_cmd && limit_ok)
                begin
                    next_state = bac_pkg::ST_RUN;
                end
                else if (start_cmd)
                begin
                    reject_evt = 1'b1;
                end
            end
            bac_pkg::ST_RUN:
            begin
                if (cmp_valid_in)
                begin
                    next_bit_cnt = bit_cnt + 1'b1;
                    if (cmp_error_in)
                    begin
                        next_err_cnt = err_cnt + 32'h1;
                        if (cmp_expected_in)
                            next_err1_cnt = err1_cnt + 32'h1;
                        else
                            next_err0_cnt = err0_cnt + 32'h1;
                    end
                end
                if (tick == 32'(TICK_CYCLES - 1))
                begin
                    next_tick = 32'h0;
                    next_elapsed = elapsed + 32'h1;
                end
                else
                begin
                    next_tick = tick + 32'h1;
                end
                // The elapsed ceiling ends every mode, so manual runs are bounded too.
                if (stop_cmd
                    || next_elapsed >= bac_pkg::MAX_TENTHS
                    || (mode == bac_pkg::MODE_DURATION && next_elapsed >= dur_lim)
                    || (mode == bac_pkg::MODE_BITS && next_bit_cnt >= bit_lim)
                    || (mode == bac_pkg::MODE_ERRORS && next_err_cnt >= err_lim))
                begin
                    next_state = bac_pkg::ST_IDLE;
                    stop_evt = 1'b1;
                end
            end
            default:
            begin
                next_state = bac_pkg::ST_IDLE;
            end
        endcase

        // Restoring divider, one quotient bit per cycle; the ratio lags the counts by a pass.
        if (div_step == 6'h0)
        begin
            next_rem = {1'b0, 32'h0, err_cnt};
            next_den = bit_cnt;
            next_quot = 32'h0;
            next_div_step = 6'h1;
        end
        else
        begin
            rem_shift = {rem[CNT_W-1:0], 1'b0};
            if (rem_shift >= {1'b0, den})
            begin
                next_rem = rem_shift - {1'b0, den};
                next_quot = {quot[30:0], 1'b1};
            end
            else
            begin
                next_rem = rem_shift;
                next_quot = {quot[30:0], 1'b0};
            end
            if (div_step == 6'(bac_pkg::RATIO_W))
            begin
                next_div_step = 6'h0;
                if (!(clear_cmd || start_cmd) || state == bac_pkg::ST_RUN)
                    next_ratio = (den == '0) ? 32'h0 : next_quot;
            end
            else
            begin
                next_div_step = div_step + 6'h1;
            end
        end

        // A read-clear and a new event in the same cycle keep the event.
        next_irq_stat = (rd_clr ? '0 : irq_stat);
        next_irq_stat[bac_pkg::IRQ_DONE] = next_irq_stat[bac_pkg::IRQ_DONE] | stop_evt;
        next_irq_stat[bac_pkg::IRQ_REJECT] = next_irq_stat[bac_pkg::IRQ_REJECT] | reject_evt;
        next_irq = |(next_irq_stat & irq_mask);
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state <= bac_pkg::ST_IDLE;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= bac_pkg::RESP_OKAY;
            arready <= 1'b1;
            rvalid <= 1'b0;
            rresp <= bac_pkg::RESP_OKAY;
            rdata <= 32'h0;
            mode <= bac_pkg::MODE_MANUAL;
            dur_lim <= 32'h0;
            err_lim <= 32'h0;
            bit_lim <= 64'h0;
            irq_stat <= '0;
            irq_mask <= '0;
            irq <= 1'b0;
            bit_cnt <= '0;
            err_cnt <= 32'h0;
            err1_cnt <= 32'h0;
            err0_cnt <= 32'h0;
            elapsed <= 32'h0;
            tick <= 32'h0;
            ratio <= 32'h0;
            quot <= 32'h0;
            rem <= '0;
            den <= '0;
            div_step <= 6'h0;
        end
        else
        begin
            state <= next_state;
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
            mode <= next_mode;
            dur_lim <= next_dur_lim;
            err_lim <= next_err_lim;
            bit_lim <= next_bit_lim;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            irq <= next_irq;
            bit_cnt <= next_bit_cnt;
            err_cnt <= next_err_cnt;
            err1_cnt <= next_err1_cnt;
            err0_cnt <= next_err0_cnt;
            elapsed <= next_elapsed;
            tick <= next_tick;
            ratio <= next_ratio;
            quot <= next_quot;
            rem <= next_rem;
            den <= next_den;
            div_step <= next_div_step;
        end
    end

    assign s_axi_awready_out = awready;
    assign s_axi_wready_out = wready;
    assign s_axi_bvalid_out = bvalid;
    assign s_axi_bresp_out = bresp;
    assign s_axi_arready_out = arready;
    assign s_axi_rvalid_out = rvalid;
    assign s_axi_rresp_out = rresp;
    assign s_axi_rdata_out = rdata;
    assign running_out = state;
    assign irq_out = irq;
endmodule
`default_nettype wire

// ### verif/bac_chk.sv
// Port-level assertions for the accumulated error-rate controller.
`timescale 1ns/1ps
`default_nettype none
module bac_chk (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [bac_pkg::ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic s_axi_rvalid_out,
    input wire logic running_out,
    input wire logic irq_out
);
    logic [1:0] mode_q, next_mode;
    logic wr_take;
    // No port shows the mode, so bus writes are shadowed.
    assign wr_take = s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
    always_comb
    begin
        next_mode = mode_q;
        if (wr_take && s_axi_awaddr_in == bac_pkg::OFF_MODE)
        begin
            next_mode = s_axi_wdata_in[1:0];
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            mode_q <= bac_pkg::MODE_MANUAL;
        end
        else
        begin
            mode_q <= next_mode;
        end
    end
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);
    a_start_by_write: assert property ($rose(running_out) |-> s_axi_bvalid_out)
        else $error("start without a write");
    a_manual_runs: assert property (running_out && mode_q == bac_pkg::MODE_MANUAL |=> running_out || s_axi_bvalid_out)
        else $error("manual run ended unbidden");
    a_read_latency: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read answer late");
    a_write_latency: assert property (wr_take |-> ##2 s_axi_bvalid_out)
        else $error("write response late");
    a_write_block: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
        else $error("write taken during response");
    a_read_block: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
        else $error("read taken during answer");
    a_irq_rise_cause: assert property ($rose(irq_out) |-> s_axi_bvalid_out || $past(s_axi_bvalid_out)
        || $past(running_out))
        else $error("irq rose without cause");
    a_irq_fall_cause: assert property ($fell(irq_out) |-> s_axi_rvalid_out || $past(s_axi_bvalid_out))
        else $error("irq fell without access");
    c_stop: cover property ($fell(running_out));
    c_irq: cover property ($rose(irq_out));
    c_err_mode: cover property (running_out && mode_q == bac_pkg::MODE_ERRORS);
endmodule
bind bac_top bac_chk u_chk (.*);
`default_nettype wire

// ### verif/bac_cmp_model.sv
// Behavioural bit-comparison stage that feeds compared bits and error flags.
`timescale 1ns/1ps
`default_nettype none
module bac_cmp_model (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic restart_in,
    input wire logic running_in,
    input wire logic [15:0] bit_total_in,
    output logic valid_out,
    output logic error_out,
    output logic expected_out
);
    logic [15:0] sent;
    logic [15:0] next_sent;
    logic junk;
    // Every fourth bit is errored and the expected value flips every four bits.
    // Idle lines toggle so that a stale value is never mistaken for a bit.
    assign valid_out = running_in && (sent < bit_total_in);
    assign error_out = valid_out ? (sent[1:0] == 2'h0) : junk;
    assign expected_out = valid_out ? sent[2] : ~junk;
    always_comb
    begin
        next_sent = restart_in ? 16'h0 : sent + {15'h0, valid_out};
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sent <= 16'h0;
            junk <= 1'h0;
        end
        else
        begin
            sent <= next_sent;
            junk <= ~junk;
        end
    end
endmodule
`default_nettype wire

// ### verif/tb.sv
// Self-checking testbench for the accumulated error-rate controller.
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed {logic [1:0] mode; logic [63:0] lim; logic run;} bac_row_t;
    logic clk_sys_in = 1'h0;
    logic rst_n_in = 1'h0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, restart = 1'h0;
    logic [15:0] total = 16'h0;
    logic awready, wready, bvalid, arready, rvalid, running_out, irq_out, cv, ce, cx;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd, b;
    int error_cnt = 0, num_checks = 0, cycles = 0;
    bac_row_t rows [11] = '{'{2'h1, 64'h0, 1'h0}, '{2'h1, 64'h05F5E0FF, 1'h1}, '{2'h1, 64'h05F5E100, 1'h0},
        '{2'h2, 64'h05F5E0FF, 1'h0}, '{2'h2, 64'h05F5E100, 1'h1}, '{2'h2, bac_pkg::BITLIM_MAX, 1'h1},
        '{2'h2, bac_pkg::BITLIM_MAX + 64'h1, 1'h0}, '{2'h3, 64'h0, 1'h0}, '{2'h3, 64'h1, 1'h1},
        '{2'h3, 64'h05F5E100, 1'h0}, '{2'h0, 64'h0, 1'h1}};
    bac_top #(.TICK_CYCLES(10)) DUT (.clk_sys_in, .rst_n_in, .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(1'h1), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(1'h1),
        .cmp_valid_in(cv), .cmp_error_in(ce), .cmp_expected_in(cx), .running_out, .irq_out);
    bac_cmp_model MODEL (.clk_sys_in, .rst_n_in, .restart_in(restart), .running_in(running_out),
        .bit_total_in(total), .valid_out(cv), .error_out(ce), .expected_out(cx));
    initial forever #5 clk_sys_in = ~clk_sys_in;
    task results;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Far above the run's length; only a hang gets here.
    always @(posedge clk_sys_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 8000)
        begin
            error_cnt++;
            results();
        end
    end
    task check(input string nm, input logic [31:0] exp, got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        forever
        begin
            @(posedge clk_sys_in);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        rs = bresp;
    endtask
    task cmd(input logic [31:0] d);
        wr(bac_pkg::OFF_CTRL, d);
    endtask
    task rdr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'h1;
        forever
        begin
            @(posedge clk_sys_in);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        rd = rdata;
        rs = rresp;
    endtask
    task counts(input logic [31:0] nb, e, e1, e0);
        rdr(bac_pkg::OFF_BITS_LO);
        check("bits", nb, rd);
        rdr(bac_pkg::OFF_ERRS);
        check("errs", e, rd);
        rdr(bac_pkg::OFF_ERR1);
        check("err1", e1, rd);
        rdr(bac_pkg::OFF_ERR0);
        check("err0", e0, rd);
    endtask
    task go(input logic [15:0] n);
        total <= n;
        restart <= 1'h1;
        cyc(1);
        restart <= 1'h0;
    endtask
    initial
    begin
        cyc(6);
        rst_n_in <= 1'h1;
        cyc(1);
        wr(bac_pkg::OFF_IRQ_MASK, 32'h2);
        foreach (rows[k])
        begin
            wr(bac_pkg::OFF_MODE, {30'h0, rows[k].mode});
            wr(rows[k].mode == 2'h2 ? bac_pkg::OFF_BITLIM_LO : rows[k].mode == 2'h3 ? bac_pkg::OFF_ERRLIM :
                bac_pkg::OFF_DUR, rows[k].lim[31:0]);
            wr(bac_pkg::OFF_BITLIM_HI, rows[k].lim[63:32]);
            cmd(32'h1);
            rdr(bac_pkg::OFF_STATUS);
            check("running", {31'h0, rows[k].run}, rd);
            check("irq", {31'h0, ~rows[k].run}, {31'h0, irq_out});
            rdr(bac_pkg::OFF_IRQ_STAT);
            check("refused", {31'h0, ~rows[k].run}, {31'h0, rd[1]});
            cyc(2);
            check("irq cleared", 32'h0, {31'h0, irq_out});
            cmd(32'h2);
            $display("limit row %0d done", k);
        end
        wr(bac_pkg::OFF_MODE, 32'h0);
        go(40);
        cmd(32'h1);
        cyc(60);
        cmd(32'h2);
        counts(40, 10, 5, 5);
        rdr(bac_pkg::OFF_ELAPSED);
        check("elapsed", 32'h1, {31'h0, rd != 32'h0});
        cyc(70);
        rdr(bac_pkg::OFF_RATIO);
        check("ratio", 32'h4000_0000, rd);
        cmd(32'h4);
        counts(0, 0, 0, 0);
        cyc(70);
        rdr(bac_pkg::OFF_RATIO);
        check("ratio zero", 32'h0, rd);
        $display("manual run and clear done");
        wr(bac_pkg::OFF_IRQ_MASK, 32'h1);
        wr(bac_pkg::OFF_ERRLIM, 32'h5);
        wr(bac_pkg::OFF_MODE, 32'h3);
        go(8);
        cmd(32'h1);
        cyc(20);
        cmd(32'h4);
        counts(8, 2, 1, 1);
        total <= 16'd40;
        while (running_out) @(posedge clk_sys_in);
        counts(17, 5, 2, 3);
        check("done irq", 32'h1, {31'h0, irq_out});
        rdr(bac_pkg::OFF_IRQ_STAT);
        check("done flag", 32'h1, {31'h0, rd[0]});
        cyc(2);
        check("irq cleared", 32'h0, {31'h0, irq_out});
        $display("error limit run done");
        wr(bac_pkg::OFF_DUR, 32'h3);
        wr(bac_pkg::OFF_MODE, 32'h1);
        go(1000);
        cmd(32'h1);
        while (running_out) @(posedge clk_sys_in);
        rdr(bac_pkg::OFF_ELAPSED);
        check("elapsed", 32'h3, rd);
        rdr(bac_pkg::OFF_BITS_LO);
        b = rd;
        rdr(bac_pkg::OFF_ERRS);
        check("errs", (b + 32'h3) / 32'h4, rd);
        $display("duration run done");
        rdr(8'h40);
        check("rresp", {30'h0, bac_pkg::RESP_SLVERR}, {30'h0, rs});
        check("rdata", 32'h0, rd);
        wr(8'h44, 32'h1);
        check("bresp", {30'h0, bac_pkg::RESP_SLVERR}, {30'h0, rs});
        wr(bac_pkg::OFF_MODE, 32'h0);
        go(1000);
        cmd(32'h1);
        cyc(5);
        rst_n_in <= 1'h0;
        cyc(2);
        rst_n_in <= 1'h1;
        cyc(1);
        check("running after reset", 32'h0, {31'h0, running_out});
        counts(0, 0, 0, 0);
        $display("unmapped access and reset done");
        results();
    end
endmodule
`default_nettype wire
